//--- tone_pkg.sv
// Purpose: constants for the dual tone generator
// Assumes: special function register write port, 8-bit data
// Notes: registers are write-only; no read path exists
package tone_pkg;
   localparam logic [7:0] LOW_CODE_ADDR  = 8'hA1;
   localparam logic [7:0] HIGH_CODE_ADDR = 8'hA2;
   localparam logic [7:0] ALT_PIN_ADDR   = 8'hA3;
   localparam int         SINE_STEPS     = 23;
   localparam int         STEP_W         = 5;
   localparam int         SAMPLE_W       = 8;
   localparam int         SUM_W          = 10;
   localparam logic [8:0] STEP_EXTRA     = 9'h002;
   localparam logic [7:0] CODE_OFF       = 8'h00;
   localparam logic [7:0] CODE_RESET     = 8'h00;
   localparam logic [2:0] ALT_RESET      = 3'h0;
   localparam int         BIT_TONE       = 0;
   localparam int         BIT_MELODY     = 1;
   localparam int         BIT_SYSCLK     = 2;
   // 2 dB down is close to 0.794; applied as 203/256
   localparam logic [7:0] LOW_GAIN_NUM   = 8'hCB;
   localparam int         GAIN_SHIFT     = 8;
endpackage : tone_pkg

//--- sine_rom.sv
// Purpose: 23-entry sine sample table with registered read
// Assumes: unsigned offset-binary samples centred on 80h
// Notes: one cycle of read latency
`timescale 1ns/1ps
`default_nettype none
module sine_rom (
   input  wire logic                             i_sys_clk,
   input  wire logic [tone_pkg::STEP_W-1:0]      i_index,
   output logic      [tone_pkg::SAMPLE_W-1:0]    o_sample
);
   logic [tone_pkg::SAMPLE_W-1:0] table_w;
   // constant table, one full period in 23 steps
   always_comb begin
      case (i_index)
         5'h00: table_w = 8'h80;
         5'h01: table_w = 8'hA2;
         5'h02: table_w = 8'hC1;
         5'h03: table_w = 8'hDB;
         5'h04: table_w = 8'hEF;
         5'h05: table_w = 8'hFB;
         5'h06: table_w = 8'hFE;
         5'h07: table_w = 8'hF8;
         5'h08: table_w = 8'hE9;
         5'h09: table_w = 8'hD2;
         5'h0A: table_w = 8'hB5;
         5'h0B: table_w = 8'h91;
         5'h0C: table_w = 8'h6E;
         5'h0D: table_w = 8'h4A;
         5'h0E: table_w = 8'h2D;
         5'h0F: table_w = 8'h16;
         5'h10: table_w = 8'h07;
         5'h11: table_w = 8'h01;
         5'h12: table_w = 8'h04;
         5'h13: table_w = 8'h10;
         5'h14: table_w = 8'h24;
         5'h15: table_w = 8'h3E;
         5'h16: table_w = 8'h5D;
         default: table_w = 8'h80;
      endcase
   end
   always_ff @(posedge i_sys_clk) begin
      o_sample <= table_w;
   end
endmodule : sine_rom
`default_nettype wire

//--- sine_synth.sv
// Purpose: one digital sine synthesizer for a tone group
// Assumes: i_tick is a one-cycle prescaler pulse
// Notes: a halted synth parks at mid-scale so its group adds nothing
`timescale 1ns/1ps
`default_nettype none
module sine_synth (
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_reset,
   input  wire logic                          i_tick,
   input  wire logic [7:0]                    i_code,
   output logic      [tone_pkg::SAMPLE_W-1:0] o_sample,
   output logic                               o_running
);
   logic [8:0]                  div_q, div_d;
   logic [8:0]                  period_q;
   logic [tone_pkg::STEP_W-1:0] idx_q, idx_d;
   logic                        run_q;
   logic                        boundary_w;
   logic                        halt_w;

   assign halt_w     = (i_code == tone_pkg::CODE_OFF);
   assign boundary_w = i_tick && (div_q == 9'h000);
   assign div_d      = boundary_w ? (period_q - 9'h001) : (div_q - 9'h001);
   assign idx_d      = (idx_q == 5'(tone_pkg::SINE_STEPS - 1)) ? 5'h00 : (idx_q + 5'h01);
   assign o_running  = run_q;

   // period x+2 taken from the code at a boundary or while halted, so writes land cleanly
   always_ff @(posedge i_sys_clk) begin
      if (i_reset || !run_q) begin
         div_q    <= 9'h000;
         idx_q    <= 5'h00;
         period_q <= {1'b0, i_code} + tone_pkg::STEP_EXTRA;
         run_q    <= !i_reset && !halt_w;
      end else if (boundary_w) begin
         div_q    <= {1'b0, i_code} + tone_pkg::STEP_EXTRA - 9'h001;
         period_q <= {1'b0, i_code} + tone_pkg::STEP_EXTRA;
         idx_q    <= idx_d;
         run_q    <= !halt_w;
      end else if (i_tick) begin
         div_q    <= div_d;
      end
   end

   sine_rom u_rom (
      .i_sys_clk (i_sys_clk),
      .i_index   (idx_q),
      .o_sample  (o_sample)
   );
endmodule : sine_synth
`default_nettype wire

//--- tone_gen.sv
// Purpose: dual tone generator with its pin-function register
// Assumes: i_psc_tick is a one-cycle pulse at the prescaled clock rate
// Notes: output is a digital sum for the analog filter stage
`timescale 1ns/1ps
`default_nettype none
module tone_gen (
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_reset,
   input  wire logic                       i_psc_tick,
   input  wire logic                       i_sfr_wr,
   input  wire logic [7:0]                 i_sfr_addr,
   input  wire logic [7:0]                 i_sfr_wdata,
   input  wire logic                       i_melody_in,
   output logic      [tone_pkg::SUM_W-1:0] o_tone_sum,
   output logic                            o_gen_active,
   output logic                            o_tone_output_enable,
   output logic                            o_melody_output_enable,
   output logic                            o_melody_output,
   output logic                            o_sysclk_pin_output_enable,
   output logic                            o_sysclk_pin
);
   logic [7:0]                    low_group_tone_code_q;
   logic [7:0]                    high_group_tone_code_q;
   logic [2:0]                    alt_pin_q;
   logic [tone_pkg::SUM_W-1:0]    sum_q, sum_d;
   logic [tone_pkg::SAMPLE_W-1:0] low_smp_w, high_smp_w;
   logic                          low_run_w, high_run_w;
   logic                          wr_low_w, wr_high_w, wr_alt_w;
   logic                          gen_on_w, gen_tick_w;
   logic [15:0]                   low_scaled_w;
   logic [tone_pkg::SAMPLE_W-1:0] low_out_w, high_out_w;

   // write decode; no read path, registers are write-only
   assign wr_low_w  = i_sfr_wr && (i_sfr_addr == tone_pkg::LOW_CODE_ADDR);
   assign wr_high_w = i_sfr_wr && (i_sfr_addr == tone_pkg::HIGH_CODE_ADDR);
   assign wr_alt_w  = i_sfr_wr && (i_sfr_addr == tone_pkg::ALT_PIN_ADDR);

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         low_group_tone_code_q  <= tone_pkg::CODE_RESET;
         high_group_tone_code_q <= tone_pkg::CODE_RESET;
         alt_pin_q              <= tone_pkg::ALT_RESET;
      end else begin
         if (wr_low_w)  low_group_tone_code_q  <= i_sfr_wdata;
         if (wr_high_w) high_group_tone_code_q <= i_sfr_wdata;
         if (wr_alt_w)  alt_pin_q <= i_sfr_wdata[2:0];
      end
   end

   // both codes zero, once both synths have halted, gates the tick to every synth: generator off
   assign gen_on_w   = (low_group_tone_code_q != tone_pkg::CODE_OFF) ||
                       (high_group_tone_code_q != tone_pkg::CODE_OFF) ||
                       low_run_w || high_run_w;
   assign gen_tick_w = i_psc_tick && gen_on_w;

   sine_synth u_low (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_tick    (gen_tick_w),
      .i_code    (low_group_tone_code_q),
      .o_sample  (low_smp_w),
      .o_running (low_run_w)
   );

   sine_synth u_high (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_tick    (gen_tick_w),
      .i_code    (high_group_tone_code_q),
      .o_sample  (high_smp_w),
      .o_running (high_run_w)
   );

   // halted group sits at mid-scale; low group scaled about 2 dB down
   assign high_out_w   = high_run_w ? high_smp_w : 8'h80;
   assign low_scaled_w = ({8'h00, low_smp_w} * {8'h00, tone_pkg::LOW_GAIN_NUM})
                         + 16'h1A80;                              // recentre: 80h*53 keeps mid-scale at 80h
   assign low_out_w    = low_run_w ? low_scaled_w[15:8] : 8'h80;
   assign sum_d        = {2'b00, low_out_w} + {2'b00, high_out_w};

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         sum_q <= 10'h100;
      end else begin
         sum_q <= sum_d;
      end
   end

   assign o_tone_sum                 = sum_q;
   assign o_gen_active               = gen_on_w;
   assign o_tone_output_enable       = alt_pin_q[tone_pkg::BIT_TONE];
   assign o_melody_output_enable     = alt_pin_q[tone_pkg::BIT_MELODY];
   assign o_melody_output            = alt_pin_q[tone_pkg::BIT_MELODY] && i_melody_in;
   assign o_sysclk_pin_output_enable = alt_pin_q[tone_pkg::BIT_SYSCLK];
   assign o_sysclk_pin               = alt_pin_q[tone_pkg::BIT_SYSCLK] && i_sys_clk;
endmodule : tone_gen
`default_nettype wire

//--- tone_gen_asserts.sv
// Purpose: port-level checks for tone_gen
// Assumes: one clock, synchronous active-high reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module tone_gen_asserts (
   input wire logic                       i_sys_clk,
   input wire logic                       i_reset,
   input wire logic                       i_sfr_wr,
   input wire logic [7:0]                 i_sfr_addr,
   input wire logic [7:0]                 i_sfr_wdata,
   input wire logic                       i_melody_in,
   input wire logic [tone_pkg::SUM_W-1:0] o_tone_sum,
   input wire logic                       o_gen_active,
   input wire logic                       o_tone_output_enable,
   input wire logic                       o_melody_output_enable,
   input wire logic                       o_melody_output,
   input wire logic                       o_sysclk_pin_output_enable
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   // pin-function write decode
   wire logic alt_wr = i_sfr_wr && i_sfr_addr == tone_pkg::ALT_PIN_ADDR;
   wire logic [2:0] pins = {o_sysclk_pin_output_enable, o_melody_output_enable, o_tone_output_enable};
   a_reset_state: assert property ($fell(i_reset) |-> o_tone_sum == 10'h100 && !o_gen_active && !pins[0])
      else $error("state after reset wrong");
   a_tone_write: assert property (alt_wr |=> o_tone_output_enable == $past(i_sfr_wdata[0]))
      else $error("tone enable not loaded");
   a_melody_write: assert property (alt_wr |=> o_melody_output_enable == $past(i_sfr_wdata[1]))
      else $error("melody enable not loaded");
   a_sysclk_write: assert property (alt_wr |=> o_sysclk_pin_output_enable == $past(i_sfr_wdata[2]))
      else $error("clock pin enable not loaded");
   a_melody_gate: assert property (o_melody_output == (i_melody_in && o_melody_output_enable))
      else $error("melody output not gated");
   a_addr_ignore: assert property (i_sfr_wr && i_sfr_addr > 8'hA3 |=> $stable(pins))
      else $error("unmapped write changed pins");
   a_gen_wakes: assert property (i_sfr_wr && i_sfr_addr == tone_pkg::HIGH_CODE_ADDR && i_sfr_wdata != 8'h00
      |-> ##[1:2] o_gen_active)
      else $error("generator did not start");
   // halted synths park at mid-scale, so the idle sum is centred
   a_idle_mid: assert property (!o_gen_active [*4] |-> o_tone_sum == 10'h100)
      else $error("idle sum not centred");
   c_running: cover property (o_gen_active);
   c_melody: cover property (o_melody_output);
   c_alt_write: cover property (alt_wr);
endmodule : tone_gen_asserts
`default_nettype wire

//--- tone_pin_model.sv
// Purpose: stand-in for filters and tone pin
// Assumes: pin level follows the digital sum one clock later
// Notes: a disabled pin rests at mid-rail, never the last sample
`timescale 1ns/1ps
`default_nettype none
module tone_pin_model (
   input  wire logic                       i_sys_clk,
   input  wire logic [tone_pkg::SUM_W-1:0] i_sum,
   input  wire logic                       i_enable,
   output logic      [tone_pkg::SUM_W-1:0] o_pin_level
);
   // summed signal reaches the pin only while enabled
   always_ff @(posedge i_sys_clk) begin
      o_pin_level <= i_enable ? i_sum : 10'h100;
   end
endmodule : tone_pin_model
`default_nettype wire

//--- dual_tone_generator_tb_top.sv
// Purpose: self-checking bench for tone_gen
// Assumes: prescaler tick on every second clock
// Notes: sine period measured in clocks at that tick rate
`timescale 1ns/1ps
`default_nettype none
module dual_tone_generator_tb_top;
   logic       i_sys_clk = 1'b0, i_reset = 1'b1, i_psc_tick = 1'b0, i_sfr_wr = 1'b0, i_melody_in = 1'b0;
   logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
   logic [9:0] o_tone_sum, pin_level, hi, lo;
   logic       o_gen_active, o_tone_output_enable, o_melody_output_enable, o_melody_output;
   logic       o_sysclk_pin_output_enable, o_sysclk_pin;
   int         error_cnt = 0, comparisons = 0, cyc = 0, d;
   // pin-function enables as one compare word
   wire logic [9:0] pin_en = {7'h0, o_sysclk_pin_output_enable, o_melody_output_enable, o_tone_output_enable};
   // address, data, expected {clock pin, melody, tone} enables
   logic [18:0] rows [8] = '{{8'hA3, 8'h01, 3'h1}, {8'hA3, 8'h02, 3'h2}, {8'hA3, 8'h04, 3'h4}, {8'hA3, 8'hF8, 3'h0},
                             {8'hA3, 8'hFF, 3'h7}, {8'hA4, 8'h00, 3'h7}, {8'hA0, 8'h00, 3'h7}, {8'hA1, 8'h00, 3'h7}};
   tone_gen dut (
      .i_sys_clk                  (i_sys_clk),
      .i_reset                    (i_reset),
      .i_psc_tick                 (i_psc_tick),
      .i_sfr_wr                   (i_sfr_wr),
      .i_sfr_addr                 (i_sfr_addr),
      .i_sfr_wdata                (i_sfr_wdata),
      .i_melody_in                (i_melody_in),
      .o_tone_sum                 (o_tone_sum),
      .o_gen_active               (o_gen_active),
      .o_tone_output_enable       (o_tone_output_enable),
      .o_melody_output_enable     (o_melody_output_enable),
      .o_melody_output            (o_melody_output),
      .o_sysclk_pin_output_enable (o_sysclk_pin_output_enable),
      .o_sysclk_pin               (o_sysclk_pin)
   );
   tone_pin_model u_pin (
      .i_sys_clk   (i_sys_clk),
      .i_sum       (o_tone_sum),
      .i_enable    (o_tone_output_enable),
      .o_pin_level (pin_level)
   );
   initial begin
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   // tick and melody stimulus, plus the hang limit
   always @(posedge i_sys_clk) begin
      i_psc_tick <= ~i_psc_tick & ~i_reset;
      i_melody_in <= cyc[3];
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_sys_clk);
      i_sfr_wr <= 1'b1;
      i_sfr_addr <= a;
      i_sfr_wdata <= v;
      @(posedge i_sys_clk);
      i_sfr_wr <= 1'b0;
   endtask : wr
   // one group alone at code 3C: waveform repeats after 23*(x+2) ticks
   task automatic tone_period(input logic [7:0] a, output logic [9:0] pk);
      logic [9:0] s0;
      wr(8'hA1, 8'h00);
      wr(8'hA2, 8'h00);
      wr(a, 8'h3C);
      repeat (400) @(posedge i_sys_clk);
      #1 s0 = pin_level;
      pk = 10'h100;
      repeat (2 * tone_pkg::SINE_STEPS * 62) begin
         @(posedge i_sys_clk);
         #1 if (pin_level > pk) pk = pin_level;
      end
      chk(pin_level, s0);
      pk = pk - 10'h100;
      chk({9'h0, pk != 10'h0}, 10'h1);
   endtask : tone_period
   task automatic give_verdict();
      $display("comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (8) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      @(posedge i_sys_clk);
      #1 chk(o_tone_sum, 10'h100);
      chk({9'h0, o_tone_output_enable}, 10'h0);
      foreach (rows[i]) begin
         wr(rows[i][18:11], rows[i][10:3]);
         #1 chk(pin_en, {7'h0, rows[i][2:0]});
         chk({9'h0, o_melody_output}, {9'h0, rows[i][1] & i_melody_in});
         chk({9'h0, o_sysclk_pin}, {9'h0, rows[i][2] & i_sys_clk});
      end
      tone_period(8'hA2, hi);
      tone_period(8'hA1, lo);
      // low peak near 203/256 of high peak, one table step of slack
      d = int'(lo) * 256 - int'(hi) * 203;
      chk({9'h0, d < 640 && d > -640}, 10'h1);
      wr(8'hA1, 8'h00);
      repeat (300) @(posedge i_sys_clk);
      #1 chk(o_tone_sum, 10'h100);
      chk({9'h0, o_gen_active}, 10'h0);
      // keypad symbol 1: row code DD with column code 7F
      wr(8'hA1, 8'hDD);
      wr(8'hA2, 8'h7F);
      repeat (20) @(posedge i_sys_clk);
      #1 chk({9'h0, o_gen_active}, 10'h1);
      chk({9'h0, o_tone_sum > 10'h100}, 10'h1);
      // reset in mid-tone: pins, codes and sum fall back to idle
      @(posedge i_sys_clk);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      @(posedge i_sys_clk);
      #1 chk(o_tone_sum, 10'h100);
      chk({9'h0, o_gen_active}, 10'h0);
      chk(pin_en, 10'h0);
      @(posedge i_sys_clk);
      #1 chk(pin_level, 10'h100);
      give_verdict();
   end
endmodule : dual_tone_generator_tb_top
bind tone_gen tone_gen_asserts u_chk (.*);
`default_nettype wire
